// ==== fste_pkg.sv ====
// constants and types of the fpu status, tag and exception unit
package fste_pkg;
   // register byte offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_STAT = 6'h04;
   localparam logic [5:0] OFS_TAG = 6'h08;
   localparam logic [5:0] OFS_DLO = 6'h0C;
   localparam logic [5:0] OFS_DMID = 6'h10;
   localparam logic [5:0] OFS_DHI = 6'h14;
   localparam logic [5:0] OFS_DCTL = 6'h18;
   localparam logic [5:0] OFS_CMD = 6'h1C;
   localparam logic [5:0] OFS_RLO = 6'h20;
   localparam logic [5:0] OFS_RMID = 6'h24;
   localparam logic [5:0] OFS_RHI = 6'h28;
   localparam logic [5:0] OFS_ISTAT = 6'h2C;
   localparam logic [5:0] OFS_IMASK = 6'h30;
   localparam int NREG = 8;
   // status word fields
   localparam int SW_IE = 0;
   localparam int SW_DE = 1;
   localparam int SW_OE = 3;
   localparam int SW_PE = 5;
   localparam int SW_SF = 6;
   localparam int SW_ES = 7;
   localparam int SW_C0 = 8;
   localparam int SW_C1 = 9;
   localparam int SW_C2 = 10;
   localparam int SW_TOP = 11;
   localparam int SW_C3 = 14;
   localparam logic [15:0] SW_CLR_MASK = 16'h477F;
   // control word fields
   localparam int CW_IM = 0;
   localparam int CW_DM = 1;
   localparam int CW_OM = 3;
   localparam int CW_PC = 8;
   localparam int CW_RC = 10;
   localparam int CW_IC = 12;
   localparam logic [15:0] CW_RESET = 16'h037F;
   localparam logic [15:0] CW_WMASK = 16'h1F3F;
   // tag codes, rounding and precision codes
   localparam logic [1:0] TAG_VALID = 2'h0;
   localparam logic [1:0] TAG_ZERO = 2'h1;
   localparam logic [1:0] TAG_SPECIAL = 2'h2;
   localparam logic [1:0] TAG_EMPTY = 2'h3;
   localparam logic [1:0] RC_DOWN = 2'h1;
   localparam logic [1:0] RC_UP = 2'h2;
   localparam logic [1:0] RC_CHOP = 2'h3;
   localparam logic [1:0] PC_SGL = 2'h0;
   localparam logic [1:0] PC_DBL = 2'h2;
   // encoding constants of the extended format
   localparam int SIG_J = 63;
   localparam int SIG_Q = 62;
   localparam logic [14:0] EXP_ZERO = 15'h0000;
   localparam logic [14:0] EXP_MAX = 15'h7FFF;
   localparam logic [14:0] EXP_MAXFIN = 15'h7FFE;
   localparam logic [63:0] SIG_INF = 64'h8000_0000_0000_0000;
   localparam logic [63:0] SIG_QIND = 64'hC000_0000_0000_0000;
   localparam logic [63:0] SIG_ONES = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] PCM_SGL = 64'hFFFF_FF00_0000_0000;
   localparam logic [63:0] PCM_DBL = 64'hFFFF_FFFF_FFFF_F800;
   // interrupt status bits and bus responses
   localparam int IRQ_DONE = 0;
   localparam int IRQ_EXC = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [3:0] {
      OP_ARITH = 4'h0, OP_COMPARE = 4'h1, OP_INT_STORE = 4'h2, OP_BCD_STORE = 4'h3,
      OP_TRANSC = 4'h4, OP_EXTRACT = 4'h5, OP_PUSH = 4'h6, OP_POP = 4'h7
   } fste_op_t;
   typedef enum logic [2:0] {
      CL_ZERO = 3'h0, CL_DENORM = 3'h1, CL_NORMAL = 3'h2, CL_INF = 3'h3,
      CL_SNAN = 3'h4, CL_QNAN = 3'h5, CL_UNSUP = 3'h6
   } fste_class_t;
   typedef struct packed {
      logic sign;
      logic [14:0] exp;
      logic [63:0] sig;
   } fste_ext_t;
   typedef struct packed {
      logic fixed_ext;
      logic ovf;
      fste_op_t op;
   } fste_cmd_t;
endpackage

// ==== fste_unit.sv ====
// status word, tag word and exception logic of the fpu, behind an axi4-lite slave
//
// Overview of operation
// - stack fault sets invalid and stack-fault flags
// - cond_code_one: one on overflow, zero underflow
// - infinity bit writable, arithmetic stays affine
// - tag load: 11 empty, others non-empty
// - operand class comes from register contents
// - tag store derives tags from contents
// - unsupported encodings get special tag 10
// - produced nans are quiet; qnan normally silent
// - snan invalid; compare/stores also on qnan
// - pseudo and unnormal operands raise invalid
// - masked denormal: operand normalized
// - transcendental and extract raise denormal too
// - masked chop overflow gives largest finite
// - unmasked overflow also sets precision flag
// - unmasked overflow significand cut to precision
// - condition codes at bits 8,9,10,14
`timescale 1ns/10ps
`default_nettype none
module fste_unit
   import fste_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);
   // operand class from the encoding alone
   function automatic fste_class_t classify(input fste_ext_t v);
      fste_class_t c;
      c = CL_NORMAL;
      if (v.exp == EXP_ZERO) begin
         c = (v.sig == '0) ? CL_ZERO : CL_DENORM;
      end else if (!v.sig[SIG_J]) begin
         c = CL_UNSUP;  // unnormal, pseudo-zero, pseudo-nan, pseudo-inf
      end else if (v.exp == EXP_MAX) begin
         if (v.sig[SIG_Q:0] == '0) begin
            c = CL_INF;
         end else begin
            c = v.sig[SIG_Q] ? CL_QNAN : CL_SNAN;
         end
      end
      return c;
   endfunction

   // tag code of a class
   function automatic logic [1:0] tag_of(input fste_class_t c);
      logic [1:0] t;
      case (c)
         CL_ZERO: t = TAG_ZERO;
         CL_NORMAL: t = TAG_VALID;
         default: t = TAG_SPECIAL;
      endcase
      return t;
   endfunction

   // leading zeros of a significand
   function automatic logic [5:0] lzc(input logic [63:0] s);
      logic [5:0] n;
      n = 6'h00;
      for (int i = 0; i < 64; i++) begin
         if (s[i]) begin
            n = 6'(63 - i);
         end
      end
      return n;
   endfunction

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (d & m);
   endfunction

   logic aw_have_r;
   logic w_have_r;
   logic [5:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_en;
   logic [5:0] waddr;
   logic [31:0] wclr;
   logic wr_hit;
   logic [15:0] ctrl_r;
   logic [15:0] flags_r;
   logic [15:0] stat_word;
   logic [2:0] top_r;
   logic [2:0] top_dn;
   logic [NREG-1:0] empty_r;
   fste_ext_t file_r [NREG];
   fste_ext_t stage_r;
   fste_ext_t res_r;
   fste_ext_t res_nxt;
   fste_ext_t opnd;
   fste_class_t ocls;
   logic [5:0] nshift_r;
   logic [5:0] nshift_nxt;
   logic [15:0] tag_word;
   logic [15:0] tag_in;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic [1:0] irq_ev;
   fste_cmd_t cmd;
   logic op_fire;
   logic opnd_op;
   logic [15:0] set_f;
   logic c1_we;
   logic c1_val;
   logic push_ok;
   logic pop_ok;
   logic res_we;
   logic nan_inv;
   logic to_max;
   logic [63:0] pcmask;
   logic [31:0] rd_word;
   logic rd_hit;

   // write address and data latch, in either order
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 6'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_en) begin
            aw_have_r <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_en) begin
            w_have_r <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   assign wr_en = aw_have_r & w_have_r & ~s_axi_bvalid;
   assign waddr = {aw_addr_r[5:2], 2'h0};
   assign wclr = w_data_r & merge(32'h0000_0000, 32'hFFFF_FFFF, w_strb_r);
   assign wr_hit = (waddr <= OFS_IMASK) && (waddr != OFS_RLO) && (waddr != OFS_RMID)
                   && (waddr != OFS_RHI);
   assign cmd = fste_cmd_t'(w_data_r[5:0]);
   assign op_fire = wr_en && (waddr == OFS_CMD) && w_strb_r[0];
   assign opnd_op = (cmd.op != OP_PUSH) && (cmd.op != OP_POP);

   // write response
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_en) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // tags generated from register contents on every read of the tag word
   for (genvar g = 0; g < NREG; g++) begin : g_tag
      assign tag_word[2*g +: 2] = empty_r[g] ? TAG_EMPTY : tag_of(classify(file_r[g]));
   end
   assign tag_in = 16'(merge({16'h0000, tag_word}, w_data_r, w_strb_r));

   // operation execution: flags, condition code one and result
   always_comb begin
      opnd = file_r[top_r];
      ocls = classify(opnd);
      top_dn = top_r - 3'h1;
      set_f = 16'h0000;
      c1_we = 1'b0;
      c1_val = 1'b0;
      res_nxt = opnd;
      res_we = 1'b0;
      nshift_nxt = 6'h00;
      push_ok = 1'b0;
      pop_ok = 1'b0;
      nan_inv = 1'b0;
      to_max = (ctrl_r[CW_RC +: 2] == RC_CHOP) ||
               (ctrl_r[CW_RC +: 2] == RC_DOWN && !stage_r.sign) ||
               (ctrl_r[CW_RC +: 2] == RC_UP && stage_r.sign);
      case (ctrl_r[CW_PC +: 2])
         PC_SGL: pcmask = PCM_SGL;
         PC_DBL: pcmask = PCM_DBL;
         default: pcmask = SIG_ONES;
      endcase
      if (cmd.fixed_ext) begin
         pcmask = SIG_ONES;
      end
      if (op_fire) begin
         if ((cmd.op == OP_PUSH) && !empty_r[top_dn]) begin
            set_f[SW_IE] = 1'b1;
            set_f[SW_SF] = 1'b1;
            c1_we = 1'b1;
            c1_val = 1'b1;
         end else if ((cmd.op != OP_PUSH) && empty_r[top_r]) begin
            set_f[SW_IE] = 1'b1;
            set_f[SW_SF] = 1'b1;
            c1_we = 1'b1;
            c1_val = 1'b0;
         end else if (cmd.op == OP_PUSH) begin
            push_ok = 1'b1;
         end else if (cmd.op == OP_POP) begin
            pop_ok = 1'b1;
         end else begin
            res_we = 1'b1;
            // quiet nan stays silent except for compare and integer/decimal stores
            nan_inv = (ocls == CL_SNAN) || ((ocls == CL_QNAN) && ((cmd.op == OP_COMPARE) ||
                      (cmd.op == OP_INT_STORE) || (cmd.op == OP_BCD_STORE)));
            if (nan_inv || (ocls == CL_UNSUP)) begin
               set_f[SW_IE] = 1'b1;
            end
            if ((ocls == CL_DENORM) && ((cmd.op == OP_ARITH) || (cmd.op == OP_TRANSC) ||
                (cmd.op == OP_EXTRACT))) begin
               set_f[SW_DE] = 1'b1;
               if (ctrl_r[CW_DM]) begin
                  nshift_nxt = lzc(opnd.sig);
                  res_nxt.sig = opnd.sig << nshift_nxt;
               end
            end
            if (set_f[SW_IE]) begin
               // nan operands pass on quieted, all else gives the default nan
               if ((ocls == CL_SNAN) || (ocls == CL_QNAN)) begin
                  res_nxt.sig[SIG_Q] = 1'b1;
               end else begin
                  res_nxt = '{sign: 1'b1, exp: EXP_MAX, sig: SIG_QIND};
               end
            end else if (cmd.ovf && (cmd.op == OP_ARITH)) begin
               set_f[SW_OE] = 1'b1;
               set_f[SW_PE] = 1'b1;
               res_nxt = stage_r;
               if (ctrl_r[CW_OM]) begin
                  // infinity bit never consulted: closure is always affine
                  if (to_max) begin
                     res_nxt.exp = EXP_MAXFIN;
                     res_nxt.sig = SIG_ONES & pcmask;
                  end else begin
                     res_nxt.exp = EXP_MAX;
                     res_nxt.sig = SIG_INF;
                  end
               end else begin
                  res_nxt.sig = stage_r.sig & pcmask;
               end
            end
            if (classify(res_nxt) == CL_SNAN) begin
               res_nxt.sig[SIG_Q] = 1'b1;
            end
         end
      end
   end

   // control word and sticky status flags, set winning over clear
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctrl_r <= CW_RESET;
         flags_r <= 16'h0000;
      end else begin
         if (wr_en && (waddr == OFS_CTRL)) begin
            ctrl_r <= 16'(merge({16'h0000, ctrl_r}, w_data_r, w_strb_r)) & CW_WMASK;
         end
         flags_r <= (flags_r & ~((wr_en && (waddr == OFS_STAT)) ? wclr[15:0] & SW_CLR_MASK
                     : 16'h0000)) | set_f;
         if (c1_we) begin
            flags_r[SW_C1] <= c1_val;
         end
      end
   end

   // status word assembly with top pointer and summary bit
   always_comb begin
      stat_word = flags_r;
      stat_word[SW_TOP +: 3] = top_r;
      stat_word[SW_ES] = |(flags_r[5:0] & ~ctrl_r[5:0]);
   end

   // register stack, staging word and result
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         top_r <= 3'h0;
         empty_r <= '1;
         stage_r <= '0;
         res_r <= '0;
         nshift_r <= 6'h00;
         for (int i = 0; i < NREG; i++) begin
            file_r[i] <= '0;
         end
      end else begin
         if (wr_en && (waddr == OFS_DLO)) begin
            stage_r.sig[31:0] <= merge(stage_r.sig[31:0], w_data_r, w_strb_r);
         end
         if (wr_en && (waddr == OFS_DMID)) begin
            stage_r.sig[63:32] <= merge(stage_r.sig[63:32], w_data_r, w_strb_r);
         end
         if (wr_en && (waddr == OFS_DHI)) begin
            {stage_r.sign, stage_r.exp} <= 16'(merge({16'h0000, stage_r.sign, stage_r.exp},
                                                      w_data_r, w_strb_r));
         end
         if (wr_en && (waddr == OFS_DCTL) && w_strb_r[0]) begin
            file_r[w_data_r[2:0]] <= stage_r;
            empty_r[w_data_r[2:0]] <= 1'b0;
         end
         if (wr_en && (waddr == OFS_TAG)) begin
            for (int i = 0; i < NREG; i++) begin
               empty_r[i] <= (tag_in[2*i +: 2] == TAG_EMPTY);
            end
         end
         if (push_ok) begin
            file_r[top_dn] <= stage_r;
            empty_r[top_dn] <= 1'b0;
            top_r <= top_dn;
         end
         if (pop_ok) begin
            empty_r[top_r] <= 1'b1;
            top_r <= top_r + 3'h1;
         end
         if (res_we) begin
            res_r <= res_nxt;
            nshift_r <= nshift_nxt;
         end
      end
   end

   // interrupt status, mask and output
   assign irq_ev = {op_fire && (|(set_f[5:0] & ~ctrl_r[5:0])), op_fire};
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_stat_r <= 2'h0;
         irq_mask_r <= 2'h0;
         irq <= 1'b0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~((wr_en && (waddr == OFS_ISTAT)) ? wclr[1:0] : 2'h0))
                       | irq_ev;
         if (wr_en && (waddr == OFS_IMASK) && w_strb_r[0]) begin
            irq_mask_r <= w_data_r[1:0];
         end
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   // read data selection
   always_comb begin
      rd_hit = 1'b1;
      case ({s_axi_araddr[5:2], 2'h0})
         OFS_CTRL: rd_word = {16'h0000, ctrl_r};
         OFS_STAT: rd_word = {16'h0000, stat_word};
         OFS_TAG: rd_word = {16'h0000, tag_word};
         OFS_DLO: rd_word = stage_r.sig[31:0];
         OFS_DMID: rd_word = stage_r.sig[63:32];
         OFS_DHI: rd_word = {16'h0000, stage_r.sign, stage_r.exp};
         OFS_DCTL: rd_word = 32'h0000_0000;
         OFS_CMD: rd_word = 32'h0000_0000;
         OFS_RLO: rd_word = res_r.sig[31:0];
         OFS_RMID: rd_word = res_r.sig[63:32];
         OFS_RHI: rd_word = {10'h000, nshift_r, res_r.sign, res_r.exp};
         OFS_ISTAT: rd_word = {30'h0000_0000, irq_stat_r};
         OFS_IMASK: rd_word = {30'h0000_0000, irq_mask_r};
         default: begin
            rd_word = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // read channel
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // checks on the exception behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   chk_fault_both_flags: assert property (
      op_fire && (cmd.op != OP_PUSH) && empty_r[top_r] |=> flags_r[SW_IE] && flags_r[SW_SF])
      else $error("stack underflow did not set invalid and stack fault");
   chk_c1_overflow_one: assert property (
      op_fire && (cmd.op == OP_PUSH) && !empty_r[top_r - 3'h1] |=> flags_r[SW_C1] && $stable(top_r))
      else $error("stack overflow did not set condition code one");
   chk_c1_underflow_zero: assert property (
      op_fire && (cmd.op != OP_PUSH) && empty_r[top_r] |=> !flags_r[SW_C1])
      else $error("stack underflow did not clear condition code one");
   chk_tag_load_empty: assert property (
      wr_en && (waddr == OFS_TAG) && w_strb_r[0] |=> empty_r[0] == ($past(w_data_r[1:0]) == 2'h3))
      else $error("tag load misread empty code");
   chk_nan_result_quiet: assert property (
      $changed(res_r) && (res_r.exp == EXP_MAX) && res_r.sig[SIG_J] && (res_r.sig[SIG_Q:0] != '0)
      |-> res_r.sig[SIG_Q])
      else $error("unit produced a signalling nan");
   chk_snan_invalid: assert property (
      op_fire && opnd_op && !empty_r[top_r] && (ocls == CL_SNAN) |=> flags_r[SW_IE] ##1 $stable(top_r))
      else $error("signalling nan operand did not raise invalid");
   chk_unsup_invalid: assert property (
      op_fire && opnd_op && !empty_r[top_r] && (ocls == CL_UNSUP)
      |=> flags_r[SW_IE] && (res_r.sig == SIG_QIND))
      else $error("unsupported operand not flagged invalid");
   chk_denorm_extract: assert property (
      op_fire && (cmd.op == OP_EXTRACT) && !empty_r[top_r] && (ocls == CL_DENORM)
      |=> flags_r[SW_DE])
      else $error("extract on denormal did not raise denormal");
   chk_chop_overflow_max: assert property (
      op_fire && cmd.ovf && (cmd.op == OP_ARITH) && !empty_r[top_r] && !set_f[SW_IE]
      && ctrl_r[CW_OM] && (ctrl_r[CW_RC +: 2] == RC_CHOP) |=> res_r.exp == EXP_MAXFIN)
      else $error("masked chop overflow did not give largest finite");
   chk_unmasked_ovf_pe: assert property (
      op_fire && cmd.ovf && (cmd.op == OP_ARITH) && !empty_r[top_r] && !set_f[SW_IE]
      && !ctrl_r[CW_OM] |=> flags_r[SW_PE] && flags_r[SW_OE])
      else $error("unmasked overflow did not set precision flag");

   cov_push_overflow: cover property (op_fire && (cmd.op == OP_PUSH) && !empty_r[top_dn]);
   cov_masked_overflow: cover property (op_fire && cmd.ovf && ctrl_r[CW_OM] && res_we);
   cov_denorm_normalized: cover property (op_fire && set_f[SW_DE] && ctrl_r[CW_DM]);
   cov_irq_raised: cover property (irq_ev[IRQ_EXC] ##[1:3] irq);
endmodule
`default_nettype wire

// ==== fste_core_model.sv ====
// axi4-lite master standing in for the integer core
`timescale 1ns/10ps
`default_nettype none
module fste_core_model (
   input wire logic sys_clk,
   output logic [5:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [5:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // idle bus; responses always accepted, so no ready toggles twice
   initial begin
      s_axi_awaddr = 6'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_araddr = 6'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b1;
   end
   // one write; each channel held until its own ready edge
   task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask
   // one read; data taken at the rvalid edge
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
   endtask
endmodule
`default_nettype wire

// ==== fste_unit_tb.sv ====
// self-checking bench of the fpu status, tag and exception unit
`timescale 1ns/10ps
`default_nettype none
module fste_unit_tb
   import fste_pkg::*;
();
   typedef struct packed {
      logic [31:0] sig;
      logic [15:0] se;
      logic [15:0] cw;
      logic [7:0] cmd;
      logic [15:0] sw;
      logic [1:0] tag;
   } fste_row_t;
   logic sys_clk, srst, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int num_errors, samples_checked;
   // operand, control, command, then expected status and tag of slot 0
   fste_row_t rows [15] = '{
      '{32'h8000_0000, 16'h3FFF, 16'h037F, 8'h00, 16'h0000, 2'h0},
      '{32'h0000_0000, 16'h0000, 16'h037F, 8'h00, 16'h0000, 2'h1},
      '{32'hA000_0000, 16'h7FFF, 16'h037F, 8'h00, 16'h0001, 2'h2},
      '{32'hC000_0000, 16'h7FFF, 16'h037F, 8'h00, 16'h0000, 2'h2},
      '{32'hC000_0000, 16'h7FFF, 16'h037F, 8'h01, 16'h0001, 2'h2},
      '{32'hC000_0000, 16'h7FFF, 16'h037F, 8'h02, 16'h0001, 2'h2},
      '{32'hC000_0000, 16'h7FFF, 16'h037F, 8'h03, 16'h0001, 2'h2},
      '{32'h0000_0000, 16'h3FFF, 16'h037F, 8'h00, 16'h0001, 2'h2},
      '{32'h4000_0000, 16'h3FFF, 16'h037F, 8'h00, 16'h0001, 2'h2},
      '{32'h0000_0000, 16'h7FFF, 16'h037F, 8'h00, 16'h0001, 2'h2},
      '{32'h4000_0000, 16'h0000, 16'h037F, 8'h04, 16'h0002, 2'h2},
      '{32'h4000_0000, 16'h0000, 16'h037F, 8'h05, 16'h0002, 2'h2},
      '{32'h8000_0000, 16'h7FFF, 16'h137F, 8'h00, 16'h0000, 2'h2},
      '{32'hFFFF_FFFF, 16'h7FFE, 16'h0F7F, 8'h10, 16'h0028, 2'h0},
      '{32'hFFFF_FFFF, 16'h7FFE, 16'h0F77, 8'h10, 16'h00A8, 2'h0}};
   fste_unit u_fste_unit (.sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
   fste_core_model u_fste_core_model (.sys_clk, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
   // 250 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic w(input logic [5:0] a, input logic [31:0] d);
      logic [1:0] r;
      u_fste_core_model.wr(a, d, r);
   endtask
   task automatic rc(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] d;
      u_fste_core_model.rd(a, d);
      chk(d, e);
   endtask
   // staging words copied into one physical slot
   task automatic ld(input logic [63:0] s, input logic [15:0] se, input logic [2:0] i);
      w(OFS_DLO, s[31:0]);
      w(OFS_DMID, s[63:32]);
      w(OFS_DHI, {16'h0000, se});
      w(OFS_DCTL, {29'h0000_0000, i});
   endtask
   task automatic op(input logic [63:0] s, input logic [15:0] se, input logic [15:0] cw,
         input logic [7:0] cmd);
      w(OFS_CTRL, {16'h0000, cw});
      ld(s, se, 3'h0);
      w(OFS_CMD, {24'h00_0000, cmd});
   endtask
   // main sequence: reset, stack faults, tags, table, results, irq, bus errors
   initial begin
      logic [1:0] resp;
      num_errors = 0;
      samples_checked = 0;
      srst = 1'b1;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      rc(OFS_CTRL, 32'h0000_037F);
      rc(OFS_TAG, 32'h0000_FFFF);
      w(OFS_CTRL, 32'h0000_037E);
      w(OFS_CMD, 32'h0000_0000);
      rc(OFS_STAT, 32'h0000_00C1);
      w(OFS_STAT, 32'h0000_477F);
      ld(SIG_INF, 16'h3FFF, 3'h0);
      ld(SIG_INF, 16'h3FFF, 3'h7);
      w(OFS_CMD, 32'h0000_0006);
      rc(OFS_STAT, 32'h0000_02C1);
      w(OFS_STAT, 32'h0000_477F);
      w(OFS_TAG, 32'h0000_0000);
      rc(OFS_TAG, 32'h0000_1554);
      w(OFS_TAG, 32'h0000_FFFE);
      rc(OFS_TAG, 32'h0000_FFFC);
      w(OFS_CMD, 32'h0000_0000);
      rc(OFS_STAT, 32'h0000_0000);
      w(OFS_TAG, 32'h0000_FFFF);
      foreach (rows[k]) begin
         w(OFS_STAT, 32'h0000_477F);
         op({rows[k].sig, 32'h0000_0000}, rows[k].se, rows[k].cw, rows[k].cmd);
         rc(OFS_TAG, {16'h0000, 14'h3FFF, rows[k].tag});
         rc(OFS_STAT, {16'h0000, rows[k].sw});
      end
      op(SIG_ONES, 16'hC123, 16'h0F7F, 8'h10);
      rc(OFS_RHI, 32'h0000_FFFE);
      rc(OFS_RLO, 32'hFFFF_FFFF);
      op(SIG_ONES, 16'h4123, 16'h0C77, 8'h10);
      rc(OFS_RMID, 32'hFFFF_FF00);
      rc(OFS_RLO, 32'h0000_0000);
      op(SIG_ONES, 16'h4123, 16'h0E77, 8'h10);
      rc(OFS_RLO, 32'hFFFF_F800);
      op(SIG_ONES, 16'h4123, 16'h0C77, 8'h30);
      rc(OFS_RLO, 32'hFFFF_FFFF);
      op(64'hA000_0000_0000_0000, 16'h7FFF, 16'h037F, 8'h00);
      rc(OFS_RMID, 32'hE000_0000);
      op(64'h4000_0000_0000_0000, 16'h0000, 16'h037F, 8'h00);
      rc(OFS_RMID, 32'h8000_0000);
      rc(OFS_RHI, 32'h0001_0000);
      w(OFS_ISTAT, 32'h0000_0003);
      w(OFS_IMASK, 32'h0000_0000);
      op(SIG_INF, 16'h3FFF, 16'h037F, 8'h00);
      rc(OFS_ISTAT, 32'h0000_0001);
      op(64'hA000_0000_0000_0000, 16'h7FFF, 16'h037E, 8'h00);
      rc(OFS_ISTAT, 32'h0000_0003);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      w(OFS_IMASK, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      w(OFS_ISTAT, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      u_fste_core_model.wr(6'h34, 32'hFFFF_FFFF, resp);
      chk({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR});
      u_fste_core_model.wr(OFS_RLO, 32'hFFFF_FFFF, resp);
      chk({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR});
      rc(6'h34, 32'h0000_0000);
      chk({30'h0000_0000, s_axi_rresp}, {30'h0000_0000, RESP_SLVERR});
      w(OFS_CTRL, 32'h0000_FFFF);
      rc(OFS_CTRL, 32'h0000_1F3F);
      final_report();
   end
   // roughly 640 bus cycles expected; 50000 cycles means a hang
   initial begin
      #200000;
      num_errors++;
      final_report();
   end
endmodule
`default_nettype wire
